// ===== hdl/lbpw_preset.sv
// power-up brightness preset logic behind the single brightness control wire
//
// Overview of operation
// - first edge outside the setup window: presetting ignored, start at full brightness.
// - led drive stays off until wire is high 140 us after last preset edge.
// - shutdown clears stored level and counting direction back to defaults.
// - in presetting the very first falling edge counts as a brightness step.
// - no direction change recognised while presetting; counter stays counting down.
// - without a valid preset the device starts at level 15, counting down.
// - counting down below level 0 wraps the level to 15.
// - level changes only on falling edges and at shutdown (back to 15); other changes depend on timed levels.
module lbpw_preset #(
  parameter int unsigned WindowOpenCyc  = lbpw_pkg::WINDOW_OPEN_CYC,
  parameter int unsigned WindowCloseCyc = lbpw_pkg::WINDOW_CLOSE_CYC,
  parameter int unsigned DriveDelayCyc  = lbpw_pkg::DRIVE_DELAY_CYC,
  parameter int unsigned PowerDownCyc   = lbpw_pkg::POWER_DOWN_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         brightnessControlWire,
  output logic [lbpw_pkg::LEVEL_W-1:0]      brightnessLevel,
  output logic                              countDown,
  output logic                              driveEnable,
  output logic                              presetTaken
);
  import lbpw_pkg::*;

  localparam logic [TIMER_W-1:0] OPEN_T  = TIMER_W'(WindowOpenCyc);
  localparam logic [TIMER_W-1:0] CLOSE_T = TIMER_W'(WindowCloseCyc);
  localparam logic [TIMER_W-1:0] DRIVE_T = TIMER_W'(DriveDelayCyc);
  localparam logic [TIMER_W-1:0] DOWN_T  = TIMER_W'(PowerDownCyc);
  localparam logic [TIMER_W-1:0] T_ONE   = {{(TIMER_W-1){1'b0}}, 1'b1};
  localparam logic [TIMER_W-1:0] T_ZERO  = {TIMER_W{1'b0}};

  // wire synchroniser and edge detect
  logic wireMeta;
  logic wireSync;
  logic wirePrev;
  logic wireFall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wireMeta <= 1'b0;
      wireSync <= 1'b0;
      wirePrev <= 1'b0;
    end else begin
      wireMeta <= brightnessControlWire;
      wireSync <= wireMeta;
      wirePrev <= wireSync;
    end
  end

  assign wireFall = wirePrev & ~wireSync;

  // high and low duration counters, saturating
  logic [TIMER_W-1:0] highTimer;
  logic [TIMER_W-1:0] lowTimer;
  logic [TIMER_W-1:0] next_highTimer;
  logic [TIMER_W-1:0] next_lowTimer;

  always_comb begin
    next_highTimer = T_ZERO;
    next_lowTimer  = T_ZERO;
    if (wireSync) begin
      next_highTimer = (highTimer == DRIVE_T) ? highTimer : highTimer + T_ONE;
    end else begin
      next_lowTimer = (lowTimer == DOWN_T) ? lowTimer : lowTimer + T_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      highTimer <= T_ZERO;
      lowTimer  <= T_ZERO;
    end else begin
      highTimer <= next_highTimer;
      lowTimer  <= next_lowTimer;
    end
  end

  // control state
  lbpw_state_t state;
  lbpw_state_t next_state;
  logic [LEVEL_W-1:0] next_brightnessLevel;
  logic next_countDown;
  logic next_driveEnable;
  logic next_presetTaken;
  logic inWindow;
  logic powerDown;
  logic highLongEnough;

  assign inWindow       = (highTimer >= OPEN_T) && (highTimer <= CLOSE_T);
  assign powerDown      = !wireSync && (lowTimer >= DOWN_T - T_ONE);
  assign highLongEnough = wireSync && (highTimer >= DRIVE_T - T_ONE);

  always_comb begin
    next_state           = state;
    next_brightnessLevel = brightnessLevel;
    next_countDown       = DIR_DOWN;
    next_driveEnable     = driveEnable;
    next_presetTaken     = presetTaken;
    if (powerDown) begin
      next_state           = ST_OFF;
      next_brightnessLevel = LEVEL_MAX;
      next_countDown       = DIR_DOWN;
      next_driveEnable     = 1'b0;
      next_presetTaken     = 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          next_brightnessLevel = LEVEL_MAX;
          next_driveEnable     = 1'b0;
          if (wireSync) begin
            next_state = ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (wireFall && inWindow) begin
            next_state           = ST_PRESET;
            next_presetTaken     = 1'b1;
            next_brightnessLevel = brightnessLevel - 4'h1;
          end else if (wireFall) begin
            next_state = ST_IGNORE;
          end else if (highLongEnough) begin
            next_state       = ST_RUN;
            next_driveEnable = 1'b1;
          end
        end
        ST_PRESET: begin
          if (wireFall) begin
            next_brightnessLevel = (brightnessLevel == LEVEL_MIN) ? LEVEL_MAX : brightnessLevel - 4'h1;
          end else if (highLongEnough) begin
            next_state       = ST_RUN;
            next_driveEnable = 1'b1;
          end
        end
        ST_IGNORE: begin
          if (highLongEnough) begin
            next_state       = ST_RUN;
            next_driveEnable = 1'b1;
          end
        end
        ST_RUN: begin
          next_driveEnable = 1'b1;
        end
        default: begin
          next_state           = ST_OFF;
          next_brightnessLevel = LEVEL_MAX;
          next_driveEnable     = 1'b0;
          next_presetTaken     = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= ST_OFF;
      brightnessLevel <= LEVEL_MAX;
      countDown       <= DIR_DOWN;
      driveEnable     <= 1'b0;
      presetTaken     <= 1'b0;
    end else begin
      state           <= next_state;
      brightnessLevel <= next_brightnessLevel;
      countDown       <= next_countDown;
      driveEnable     <= next_driveEnable;
      presetTaken     <= next_presetTaken;
    end
  end

  // checks
  a_first_edge_counts: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_SETUP && wireFall && inWindow && !powerDown)
      |=> (brightnessLevel == $past(brightnessLevel) - 4'h1) && state == ST_PRESET)
    else $error("first preset edge not counted");

  a_outside_window: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_SETUP && wireFall && !inWindow)
      |=> state == ST_IGNORE && brightnessLevel == LEVEL_MAX)
    else $error("edge outside setup window not ignored");

  a_level_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PRESET && wireFall && brightnessLevel == LEVEL_MIN) |=> brightnessLevel == LEVEL_MAX)
    else $error("level did not wrap to fifteen");

  a_drive_held_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PRESET && !wireSync) |=> !driveEnable ##1 !driveEnable)
    else $error("drive enabled before start-up delay");

  a_drive_after_delay: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PRESET && wireSync && highTimer == DRIVE_T - 18'h2) |=> ##1 driveEnable)
    else $error("drive not enabled after start-up delay");

  a_shutdown_clears: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!wireSync && lowTimer == DOWN_T - T_ONE)
      |=> state == ST_OFF && brightnessLevel == LEVEL_MAX && countDown && !driveEnable && !presetTaken)
    else $error("shutdown did not clear level and direction");

  a_direction_down: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PRESET) |-> countDown)
    else $error("direction changed during presetting");

  a_level_on_fall: assert property (
    @(posedge clk) disable iff (!arst_n)
    (brightnessLevel != $past(brightnessLevel)) |-> ($past(wireFall) || state == ST_OFF))
    else $error("level changed without a falling edge");

  a_default_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == ST_SETUP && !wireFall && highLongEnough) |=> driveEnable && brightnessLevel == LEVEL_MAX)
    else $error("default start not at full brightness");

  a_sync_delay: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(wireSync) |=> highTimer == T_ONE)
    else $error("high timer not started on rising wire");

endmodule : lbpw_preset

// ===== inc/lbpw_pkg.sv
// constants and state encoding for the brightness preset wire logic
package lbpw_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned TIMER_W           = 18;
  localparam int unsigned LEVEL_W           = 4;
  localparam logic [3:0]  LEVEL_MAX         = 4'hF;
  localparam logic [3:0]  LEVEL_MIN         = 4'h0;
  localparam logic        DIR_DOWN          = 1'b1;
  // times in microseconds as printed
  localparam int unsigned WINDOW_OPEN_US    = 35;
  localparam int unsigned WINDOW_CLOSE_US   = 50;
  localparam int unsigned DRIVE_DELAY_US    = 140;
  localparam int unsigned POWER_DOWN_US     = 1260;
  // least times round up, longest times round down
  localparam int unsigned WINDOW_OPEN_CYC   = (WINDOW_OPEN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WINDOW_CLOSE_CYC  = (WINDOW_CLOSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned DRIVE_DELAY_CYC   = (DRIVE_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POWER_DOWN_CYC    = (POWER_DOWN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [4:0] {
    ST_OFF    = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_PRESET = 5'b00100,
    ST_IGNORE = 5'b01000,
    ST_RUN    = 5'b10000
  } lbpw_state_t;
endpackage : lbpw_pkg

// ===== dv/lbpw_host.sv
// host model that drives the brightness control wire
module lbpw_host #(
  parameter int unsigned PowerDownCyc = 300
) (
  input  wire logic clk,
  output logic      brightnessControlWire
);
  timeunit 1ns;
  timeprecision 1ps;
  initial brightnessControlWire = 1'b0;
  // hold one level for n cycles, entered and left 1 ns after an edge
  task automatic drive(input logic v, input int n);
    brightnessControlWire = v;
    repeat (n) @(posedge clk);
    #1;
  endtask : drive
  // long low so the device reaches shutdown
  task automatic shut();
    drive(1'b0, PowerDownCyc + 20);
  endtask : shut
  // one programming pulse, widths well short of the power-down time
  task automatic pulse(input int lo, input int hi);
    drive(1'b0, lo);
    drive(1'b1, hi);
  endtask : pulse
endmodule : lbpw_host

// ===== dv/lbpw_preset_tb.sv
// self-checking bench for the brightness preset wire logic
module lbpw_preset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lbpw_pkg::*;
  localparam int unsigned WO = 20, WC = 40, DD = 100, PD = 300;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               wireLvl;
  logic [LEVEL_W-1:0] brightnessLevel;
  logic               countDown, driveEnable, presetTaken;
  logic               prevDrive = 1'b0;
  logic [16:0]        seed = 17'h11552;
  logic [4:0]         expQ[$];
  int                 fails = 0, checks = 0, highCnt = 0;

  lbpw_host #(.PowerDownCyc(PD)) host (.clk(clk), .brightnessControlWire(wireLvl));
  lbpw_preset #(
    .WindowOpenCyc(WO), .WindowCloseCyc(WC), .DriveDelayCyc(DD), .PowerDownCyc(PD)
  ) dut (
    .clk(clk), .arst_n(arst_n), .brightnessControlWire(wireLvl), .brightnessLevel(brightnessLevel),
    .countDown(countDown), .driveEnable(driveEnable), .presetTaken(presetTaken)
  );

  initial forever #2.5 clk = ~clk;

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // shutdown, rise, k falls, then wait for drive under a bound
  task automatic run(input int pre, input int k, input int lo, input int hi, input logic tk);
    int n;
    host.shut();
    chk("level after shutdown", 8'(brightnessLevel), 8'hF);
    chk("flags after shutdown", 8'({countDown, driveEnable, presetTaken}), 8'h4);
    expQ.push_back({tk, tk ? 4'(15 - k) : LEVEL_MAX});
    host.drive(1'b1, pre);
    for (n = 0; n < k; n++) host.pulse(lo, hi);
    for (n = 0; n < 200 && driveEnable !== 1'b1; n++) host.drive(1'b1, 1);
    if (driveEnable === 1'b1) begin
      // keep the wire high until the monitor has seen the drive start
      host.drive(1'b1, 2);
      $display("test done: pre %0d edges %0d", pre, k);
    end else begin
      fails++;
      close_out();
    end
  endtask : run

  // result monitor: each drive start is compared with the oldest note
  always @(negedge clk) begin
    logic [4:0] e;
    highCnt = (wireLvl === 1'b1) ? highCnt + 1 : 0;
    if (driveEnable === 1'b1 && prevDrive !== 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 5'h1F;
      chk("level at drive", 8'(brightnessLevel), 8'(e[3:0]));
      chk("preset taken", 8'(presetTaken), 8'(e[4]));
      chk("count down", 8'(countDown), 8'(DIR_DOWN));
      chk("drive delay", 8'(highCnt >= DD && highCnt <= DD + 6), 8'h1);
    end
    prevDrive = driveEnable;
  end

  initial begin
    int k;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    run(30, 5, 3, 3, 1'b1);
    run(30, 17, 2, 2, 1'b1);
    run(8, 3, 3, 3, 1'b0);
    run(50, 2, 3, 3, 1'b0);
    run(30, 0, 3, 3, 1'b0);
    repeat (4) begin
      seed = lfsr(seed);
      k = int'(seed[3:0]) % 15 + 1;
      run(22 + int'(seed[7:4]) % 14, k, 2 + int'(seed[9:8]), 2 + int'(seed[11:10]), 1'b1);
    end
    // reset in the middle of presetting brings back the defaults
    host.shut();
    host.drive(1'b1, 30);
    host.pulse(3, 3);
    chk("level before reset", 8'(brightnessLevel), 8'(LEVEL_MAX - 4'h1));
    arst_n = 1'b0;
    host.drive(1'b1, 2);
    chk("level in reset", 8'(brightnessLevel), 8'hF);
    chk("flags in reset", 8'({countDown, driveEnable, presetTaken}), 8'h4);
    arst_n = 1'b1;
    host.shut();
    chk("level at end", 8'(brightnessLevel), 8'hF);
    $display("test done: reset during presetting");
    close_out();
  end
endmodule : lbpw_preset_tb
